// ===== src/smi_device.sv
`timescale 1ns/10ps
`default_nettype none
module smi_device #(
    parameter int                     STEP_GAP_CYC = smi_pkg::STEP_GAP_CYC,
    parameter int                     OFF_TIME_CYC = smi_pkg::OFF_TIME_CYC,
    parameter logic [smi_pkg::SET_W-1:0] DECEL_RATE = smi_pkg::DECEL_DEFAULT,
    parameter logic [smi_pkg::SET_W-1:0] ENC_GAIN   = smi_pkg::GAIN_DEFAULT,
    parameter logic [smi_pkg::SET_W-1:0] PG_GAIN    = smi_pkg::GAIN_DEFAULT
) (
    input  wire logic                            REF_CLK,
    input  wire logic                            RST_B,
    smi_link_if.dev                              LINK,
    input  wire logic [smi_pkg::ANGLE_W-1:0]     POS_RAW,
    input  wire logic                            ENCODER_MODE,
    input  wire logic                            ZPHASE_PRESENT,
    input  wire logic [smi_pkg::RATIO_W-1:0]     DETECTOR_RATIO,
    input  wire logic [smi_pkg::TEETH_W-1:0]     SPINDLE_TEETH,
    input  wire logic [smi_pkg::TEETH_W-1:0]     MOTOR_TEETH,
    input  wire logic [smi_pkg::SET_W-1:0]       INPOS_WIDTH,
    output logic                                 DRIVE_EN,
    output logic                                 COAST,
    output logic                                 RUN_FWD,
    output logic [smi_pkg::ANGLE_W-1:0]          TARGET_POS,
    output logic                                 LOW_GEAR,
    output logic [smi_pkg::TL_W-1:0]             TORQUE_LIMIT,
    output logic [smi_pkg::SET_W-1:0]            DECEL_OUT,
    output logic [smi_pkg::SET_W-1:0]            LOOP_GAIN,
    output logic [smi_pkg::TEETH_W-1:0]          RATIO_NUM,
    output logic [smi_pkg::TEETH_W-1:0]          RATIO_DEN,
    output logic                                 CFG_ERR
);
    localparam int AW = smi_pkg::ANGLE_W;
    localparam int CW = smi_pkg::CNT_W;

    typedef enum logic [1:0] {
        D_COAST, D_ORIENT, D_HELD, D_INDEX
    } smi_dstate_t;

    smi_dstate_t           state_reg, state_next;
    logic                  fwd_prev_reg, fwd_prev_next;
    logic                  rev_prev_reg, rev_prev_next;
    logic                  orient_prev_reg, orient_prev_next;
    logic                  orient_done_reg, orient_done_next;
    logic                  index_done_reg, index_done_next;
    logic [CW-1:0]         gap_cnt_reg, gap_cnt_next;
    logic [CW-1:0]         off_cnt_reg, off_cnt_next;
    logic                  drive_reg, drive_next;
    logic                  coast_reg, coast_next;
    logic                  dir_reg, dir_next;
    logic [AW-1:0]         target_reg, target_next;
    logic                  low_gear_reg, low_gear_next;
    logic [2:0]            tl_reg, tl_next;
    logic [7:0]            decel_reg, decel_next;
    logic [7:0]            gain_reg, gain_next;
    logic [15:0]           num_reg, num_next;
    logic [15:0]           den_reg, den_next;
    logic                  cfg_err_reg, cfg_err_next;
    logic [2:0]            ratio_reg, ratio_next;

    logic [AW-1:0]         spindle_pos;
    logic                  inpos;
    logic                  fwd_rise;
    logic                  rev_rise;
    logic                  link_ok;

    smi_pos_tracker #(.W(AW)) u_track (
        .clk         (REF_CLK),
        .rst_b       (RST_B),
        .pos_raw     (POS_RAW),
        .ratio_code  (ratio_reg),
        .target      (target_reg),
        .width       (INPOS_WIDTH),
        .spindle_pos (spindle_pos),
        .inpos       (inpos)
    );

    always_comb begin
        fwd_rise = LINK.index_forward_cmd && !fwd_prev_reg;
        rev_rise = LINK.index_reverse_cmd && !rev_prev_reg;
        link_ok  = LINK.orient_start_cmd && LINK.machine_ready;
    end

    // configuration: ratio, gains, teeth counts
    always_comb begin
        ratio_next = smi_pkg::RATIO_RESET;
        if (ENCODER_MODE && DETECTOR_RATIO <= smi_pkg::RATIO_MAX) begin
            ratio_next = DETECTOR_RATIO;
        end
        cfg_err_next = !ENCODER_MODE &&
                       (SPINDLE_TEETH != smi_pkg::TEETH_UNITY ||
                        MOTOR_TEETH != smi_pkg::TEETH_UNITY ||
                        !ZPHASE_PRESENT);
        num_next   = SPINDLE_TEETH;
        den_next   = MOTOR_TEETH;
        decel_next = DECEL_RATE;
        gain_next  = ENCODER_MODE ? ENC_GAIN : PG_GAIN;
        tl_next    = LINK.orient_start_cmd ? LINK.torque_limit_inputs
                                           : smi_pkg::TL_NONE;
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            ratio_reg   <= smi_pkg::RATIO_RESET;
            cfg_err_reg <= 1'b0;
            num_reg     <= smi_pkg::TEETH_UNITY;
            den_reg     <= smi_pkg::TEETH_UNITY;
            decel_reg   <= smi_pkg::DECEL_DEFAULT;
            gain_reg    <= smi_pkg::GAIN_DEFAULT;
            tl_reg      <= smi_pkg::TL_NONE;
        end else begin
            ratio_reg   <= ratio_next;
            cfg_err_reg <= cfg_err_next;
            num_reg     <= num_next;
            den_reg     <= den_next;
            decel_reg   <= decel_next;
            gain_reg    <= gain_next;
            tl_reg      <= tl_next;
        end
    end

    // orientation and indexing sequencer
    always_comb begin
        state_next       = state_reg;
        fwd_prev_next    = LINK.index_forward_cmd;
        rev_prev_next    = LINK.index_reverse_cmd;
        orient_prev_next = LINK.orient_start_cmd;
        orient_done_next = orient_done_reg;
        index_done_next  = index_done_reg;
        drive_next       = drive_reg;
        coast_next       = coast_reg;
        dir_next         = dir_reg;
        target_next      = target_reg;
        low_gear_next    = low_gear_reg;
        off_cnt_next     = (off_cnt_reg != '0) ? CW'(off_cnt_reg - 1'b1)
                                               : off_cnt_reg;
        gap_cnt_next     = (gap_cnt_reg != '0) ? CW'(gap_cnt_reg - 1'b1)
                                               : gap_cnt_reg;
        if (LINK.orient_start_cmd != orient_prev_reg) begin
            gap_cnt_next = CW'(STEP_GAP_CYC);
        end
        case (state_reg)
            D_COAST: begin
                drive_next       = 1'b0;
                coast_next       = 1'b1;
                orient_done_next = 1'b0;
                index_done_next  = 1'b0;
                // only a fresh orient command starts a new stop
                if (link_ok && !orient_prev_reg && !cfg_err_reg) begin
                    state_next    = D_ORIENT;
                    target_next   = smi_pkg::ORIENT_HOME;
                    dir_next      = 1'b1;
                    drive_next    = 1'b1;
                    coast_next    = 1'b0;
                    low_gear_next = 1'b1;
                end
            end
            D_ORIENT: begin
                if (inpos) begin
                    state_next       = D_HELD;
                    orient_done_next = 1'b1;
                    gap_cnt_next     = CW'(STEP_GAP_CYC);
                end
            end
            D_HELD: begin
                // indexing only from a completed stop
                if ((fwd_rise || rev_rise) && gap_cnt_reg == '0) begin
                    state_next      = D_INDEX;
                    target_next     = LINK.stop_position_word;
                    dir_next        = fwd_rise;
                    index_done_next = 1'b0;
                    off_cnt_next    = CW'(OFF_TIME_CYC);
                end
            end
            D_INDEX: begin
                // indexing inputs are ignored until settled
                if (inpos && off_cnt_reg == '0) begin
                    state_next      = D_HELD;
                    index_done_next = 1'b1;
                    gap_cnt_next    = CW'(STEP_GAP_CYC);
                end
            end
            default: begin
                state_next = D_COAST;
            end
        endcase
        if (!link_ok && state_reg != D_COAST) begin
            state_next       = D_COAST;
            drive_next       = 1'b0;
            coast_next       = 1'b1;
            orient_done_next = 1'b0;
            index_done_next  = 1'b0;
            low_gear_next    = 1'b0;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_reg       <= D_COAST;
            fwd_prev_reg    <= 1'b0;
            rev_prev_reg    <= 1'b0;
            orient_prev_reg <= 1'b0;
            orient_done_reg <= 1'b0;
            index_done_reg  <= 1'b0;
            gap_cnt_reg     <= '0;
            off_cnt_reg     <= '0;
            drive_reg       <= 1'b0;
            coast_reg       <= 1'b1;
            dir_reg         <= 1'b1;
            target_reg      <= smi_pkg::ORIENT_HOME;
            low_gear_reg    <= 1'b0;
        end else begin
            state_reg       <= state_next;
            fwd_prev_reg    <= fwd_prev_next;
            rev_prev_reg    <= rev_prev_next;
            orient_prev_reg <= orient_prev_next;
            orient_done_reg <= orient_done_next;
            index_done_reg  <= index_done_next;
            gap_cnt_reg     <= gap_cnt_next;
            off_cnt_reg     <= off_cnt_next;
            drive_reg       <= drive_next;
            coast_reg       <= coast_next;
            dir_reg         <= dir_next;
            target_reg      <= target_next;
            low_gear_reg    <= low_gear_next;
        end
    end

    assign LINK.orient_done_out = orient_done_reg;
    assign LINK.index_done_out  = index_done_reg;
    assign DRIVE_EN     = drive_reg;
    assign COAST        = coast_reg;
    assign RUN_FWD      = dir_reg;
    assign TARGET_POS   = target_reg;
    assign LOW_GEAR     = low_gear_reg;
    assign TORQUE_LIMIT = tl_reg;
    assign DECEL_OUT    = decel_reg;
    assign LOOP_GAIN    = gain_reg;
    assign RATIO_NUM    = num_reg;
    assign RATIO_DEN    = den_reg;
    assign CFG_ERR      = cfg_err_reg;
endmodule : smi_device
`default_nettype wire

// ===== src/smi_pkg.sv
package smi_pkg;
    localparam int          ANGLE_W        = 12;
    localparam int          TL_W           = 3;
    localparam int          GEAR_W         = 2;
    localparam int          RATIO_W        = 3;
    localparam int          TEETH_W        = 16;
    localparam int          SET_W          = 8;
    localparam int          CNT_W          = 26;
    localparam int          CLK_KHZ        = 125000;
    // handshake step spacing, index-done off time, controller hold time
    localparam int          STEP_GAP_MS    = 20;
    localparam int          OFF_TIME_MS    = 200;
    localparam int          HOLD_MIN_MS    = 50;
    localparam int          STEP_GAP_CYC   = STEP_GAP_MS * CLK_KHZ;
    localparam int          OFF_TIME_CYC   = OFF_TIME_MS * CLK_KHZ;
    localparam int          HOLD_MIN_CYC   = HOLD_MIN_MS * CLK_KHZ;
    localparam logic [2:0]  RATIO_MAX      = 3'h4;
    localparam logic [2:0]  RATIO_RESET    = 3'h0;
    localparam logic [7:0]  DECEL_DEFAULT  = 8'h14;
    localparam logic [7:0]  GAIN_DEFAULT   = 8'h64;
    localparam logic [7:0]  INPOS_DEFAULT  = 8'h0E;
    localparam logic [15:0] TEETH_UNITY    = 16'h0001;
    localparam logic [11:0] ORIENT_HOME    = 12'h000;
    localparam logic [1:0]  GEAR_LOW       = 2'h0;
    localparam logic [2:0]  TL_NONE        = 3'h0;
endpackage : smi_pkg

// ===== src/smi_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface smi_link_if;
    logic                             orient_start_cmd;
    logic                             index_forward_cmd;
    logic                             index_reverse_cmd;
    logic [smi_pkg::ANGLE_W-1:0]      stop_position_word;
    logic [smi_pkg::TL_W-1:0]         torque_limit_inputs;
    logic [smi_pkg::GEAR_W-1:0]       gear_select;
    logic                             machine_ready;
    logic                             orient_done_out;
    logic                             index_done_out;

    modport dev (
        input  orient_start_cmd, index_forward_cmd, index_reverse_cmd,
        input  stop_position_word, torque_limit_inputs, gear_select,
        input  machine_ready,
        output orient_done_out, index_done_out
    );
    modport ctl (
        output orient_start_cmd, index_forward_cmd, index_reverse_cmd,
        output stop_position_word, torque_limit_inputs, gear_select,
        output machine_ready,
        input  orient_done_out, index_done_out
    );
endinterface : smi_link_if
`default_nettype wire

// ===== src/smi_pos_tracker.sv
`timescale 1ns/10ps
`default_nettype none
module smi_pos_tracker #(
    parameter int W = smi_pkg::ANGLE_W
) (
    input  wire logic                       clk,
    input  wire logic                       rst_b,
    input  wire logic [W-1:0]               pos_raw,
    input  wire logic [smi_pkg::RATIO_W-1:0] ratio_code,
    input  wire logic [W-1:0]               target,
    input  wire logic [smi_pkg::SET_W-1:0]  width,
    output logic      [W-1:0]               spindle_pos,
    output logic                            inpos
);
    logic [W-1:0] sync1_reg;
    logic [W-1:0] sync2_reg;
    logic [W-1:0] dist_fwd;
    logic [W-1:0] dist_rev;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= pos_raw;
            sync2_reg <= sync1_reg;
        end
    end

    // detector turns 1/2^code per spindle turn, so scale up to spindle angle
    always_comb begin
        spindle_pos = W'(sync2_reg << ratio_code);
        dist_fwd    = W'(target - spindle_pos);
        dist_rev    = W'(spindle_pos - target);
        inpos       = (dist_fwd <= W'(width)) || (dist_rev <= W'(width));
    end
endmodule : smi_pos_tracker
`default_nettype wire

// ===== src/smi_controller.sv
`timescale 1ns/10ps
`default_nettype none
module smi_controller #(
    parameter int STEP_GAP_CYC = smi_pkg::STEP_GAP_CYC,
    parameter int HOLD_MIN_CYC = smi_pkg::HOLD_MIN_CYC
) (
    input  wire logic                        REF_CLK,
    input  wire logic                        RST_B,
    smi_link_if.ctl                          LINK,
    input  wire logic                        ORIENT_REQ,
    input  wire logic                        READY_REQ,
    input  wire logic                        INDEX_REQ,
    input  wire logic                        INDEX_FWD,
    input  wire logic [smi_pkg::ANGLE_W-1:0] INDEX_TARGET,
    input  wire logic                        CLAMP_REQ,
    input  wire logic [smi_pkg::TL_W-1:0]    CLAMP_TL,
    output logic                             ORIENTED,
    output logic                             INDEXED,
    output logic                             BUSY
);
    localparam int CW = smi_pkg::CNT_W;

    typedef enum logic [2:0] {
        H_IDLE, H_GEAR, H_ORIENT, H_DATA, H_INDEX, H_GAP
    } smi_hstate_t;

    smi_hstate_t                  state_reg, state_next;
    logic [CW-1:0]                cnt_reg, cnt_next;
    logic                         orient_reg, orient_next;
    logic                         fwd_reg, fwd_next;
    logic                         rev_reg, rev_next;
    logic [smi_pkg::ANGLE_W-1:0]  word_reg, word_next;
    logic [smi_pkg::TL_W-1:0]     tl_reg, tl_next;
    logic                         ready_reg, ready_next;
    logic                         odone_reg, odone_next;
    logic                         idone_reg, idone_next;
    logic                         busy_reg, busy_next;

    always_comb begin
        state_next  = state_reg;
        orient_next = orient_reg;
        fwd_next    = fwd_reg;
        rev_next    = rev_reg;
        word_next   = word_reg;
        ready_next  = READY_REQ;
        odone_next  = LINK.orient_done_out;
        idone_next  = LINK.index_done_out;
        cnt_next    = (cnt_reg != '0) ? CW'(cnt_reg - 1'b1) : cnt_reg;
        tl_next     = (CLAMP_REQ && orient_reg) ? CLAMP_TL
                                                : smi_pkg::TL_NONE;
        busy_next   = (state_reg != H_IDLE) && (state_reg != H_ORIENT);
        case (state_reg)
            H_IDLE: begin
                orient_next = 1'b0;
                if (ORIENT_REQ && cnt_reg == '0) begin
                    state_next = H_GEAR;
                    cnt_next   = CW'(STEP_GAP_CYC);
                end
            end
            H_GEAR: begin
                if (cnt_reg == '0) begin
                    state_next  = H_ORIENT;
                    orient_next = 1'b1;
                    cnt_next    = CW'(STEP_GAP_CYC);
                end
            end
            H_ORIENT: begin
                if (INDEX_REQ && LINK.orient_done_out && cnt_reg == '0) begin
                    state_next = H_DATA;
                    word_next  = INDEX_TARGET;
                    fwd_next   = INDEX_FWD;
                    rev_next   = !INDEX_FWD;
                    cnt_next   = CW'(STEP_GAP_CYC);
                    fwd_next   = 1'b0;
                    rev_next   = 1'b0;
                end
            end
            H_DATA: begin
                if (cnt_reg == '0) begin
                    state_next = H_INDEX;
                    fwd_next   = INDEX_FWD;
                    rev_next   = !INDEX_FWD;
                    cnt_next   = CW'(HOLD_MIN_CYC);
                end
            end
            H_INDEX: begin
                // hold until done after the off-time dip, never under 50ms unless ORIENT_REQ drops
                if (cnt_reg == '0 && LINK.index_done_out) begin
                    state_next = H_GAP;
                    fwd_next   = 1'b0;
                    rev_next   = 1'b0;
                    cnt_next   = CW'(STEP_GAP_CYC);
                end
            end
            H_GAP: begin
                if (cnt_reg == '0) begin
                    state_next = H_ORIENT;
                end
            end
            default: begin
                state_next = H_IDLE;
            end
        endcase
        if (!ORIENT_REQ && state_reg != H_IDLE && state_reg != H_GEAR) begin
            state_next  = H_IDLE;
            orient_next = 1'b0;
            fwd_next    = 1'b0;
            rev_next    = 1'b0;
            cnt_next    = CW'(STEP_GAP_CYC);
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_reg  <= H_IDLE;
            cnt_reg    <= '0;
            orient_reg <= 1'b0;
            fwd_reg    <= 1'b0;
            rev_reg    <= 1'b0;
            word_reg   <= smi_pkg::ORIENT_HOME;
            tl_reg     <= smi_pkg::TL_NONE;
            ready_reg  <= 1'b0;
            odone_reg  <= 1'b0;
            idone_reg  <= 1'b0;
            busy_reg   <= 1'b0;
        end else begin
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            orient_reg <= orient_next;
            fwd_reg    <= fwd_next;
            rev_reg    <= rev_next;
            word_reg   <= word_next;
            tl_reg     <= tl_next;
            ready_reg  <= ready_next;
            odone_reg  <= odone_next;
            idone_reg  <= idone_next;
            busy_reg   <= busy_next;
        end
    end

    assign LINK.orient_start_cmd    = orient_reg;
    assign LINK.index_forward_cmd   = fwd_reg;
    assign LINK.index_reverse_cmd   = rev_reg;
    assign LINK.stop_position_word  = word_reg;
    assign LINK.torque_limit_inputs = tl_reg;
    assign LINK.gear_select         = smi_pkg::GEAR_LOW;
    assign LINK.machine_ready       = ready_reg;
    assign ORIENTED = odone_reg;
    assign INDEXED  = idone_reg;
    assign BUSY     = busy_reg;
endmodule : smi_controller
`default_nettype wire

// ===== tb/smi_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module smi_assertions #(
    parameter int OFF_TIME_CYC = 30,
    parameter int HOLD_MIN_CYC = 10
) (
    input wire logic                       REF_CLK,
    input wire logic                       RST_B,
    input wire logic                       orient_start_cmd,
    input wire logic                       index_forward_cmd,
    input wire logic                       index_reverse_cmd,
    input wire logic [smi_pkg::GEAR_W-1:0] gear_select,
    input wire logic                       machine_ready,
    input wire logic                       orient_done_out,
    input wire logic                       index_done_out
);
    int low_reg;
    int hold_reg;
    logic run;
    assign run = orient_start_cmd && machine_ready;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            low_reg  <= 0;
            hold_reg <= 0;
        end else begin
            low_reg  <= index_done_out ? 0 : low_reg + 1;
            hold_reg <= (index_forward_cmd || index_reverse_cmd) ?
                        hold_reg + 1 : 0;
        end
    end
    a_loss_drops_done: assert property (!run |=>
        !orient_done_out && !index_done_out)
        else $error("done output kept after abort");
    a_orient_done_cause: assert property ($rose(orient_done_out) |->
        $past(run)) else $error("orient done without command");
    a_index_needs_orient: assert property ($rose(index_done_out) |->
        $past(run) && orient_done_out) else $error("index done while not held");
    a_index_fall_cause: assert property ($fell(index_done_out) |->
        $past(!run) || $past(index_forward_cmd || index_reverse_cmd))
        else $error("index done fell without cause");
    a_off_time_held: assert property ($rose(index_done_out) |->
        low_reg >= OFF_TIME_CYC - 2) else $error("off time too short");
    a_move_finishes: assert property ($fell(index_done_out) && run |->
        ##[1:300] (index_done_out || !run)) else $error("move never ends");
    a_hold_until_done: assert property (
        $fell(index_forward_cmd || index_reverse_cmd) && run |->
        $past(index_done_out) && hold_reg >= HOLD_MIN_CYC - 1)
        else $error("index command dropped early");
    a_gear_low_kept: assert property (orient_start_cmd |->
        gear_select == smi_pkg::GEAR_LOW) else $error("gear not low");
    c_orient: cover property ($rose(orient_done_out));
    c_index: cover property ($rose(index_done_out));
    c_rev: cover property ($rose(index_reverse_cmd));
endmodule : smi_assertions
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        clk, rst_b, o_req, r_req, i_req, i_fwd, c_req;
    logic        enc, zph, drive_en, coast, run_fwd, low_gear, cfg_err;
    logic        oriented, indexed, busy;
    logic [2:0]  c_tl, ratio, tl_out;
    logic [7:0]  inpos, decel, gain;
    logic [11:0] i_tgt, pos_raw, tgt_pos;
    logic [15:0] sp_t, mt_t, r_num, r_den;
    logic [11:0] tgt [2] = '{12'h0A5C, 12'h0123};
    int          errors, cmp_count;
    smi_link_if link();
    smi_device #(.STEP_GAP_CYC(20), .OFF_TIME_CYC(30)) i_smi_device (
        .REF_CLK(clk), .RST_B(rst_b), .LINK(link.dev), .POS_RAW(pos_raw),
        .ENCODER_MODE(enc), .ZPHASE_PRESENT(zph), .DETECTOR_RATIO(ratio),
        .SPINDLE_TEETH(sp_t), .MOTOR_TEETH(mt_t), .INPOS_WIDTH(inpos),
        .DRIVE_EN(drive_en), .COAST(coast), .RUN_FWD(run_fwd),
        .TARGET_POS(tgt_pos), .LOW_GEAR(low_gear), .TORQUE_LIMIT(tl_out),
        .DECEL_OUT(decel), .LOOP_GAIN(gain), .RATIO_NUM(r_num),
        .RATIO_DEN(r_den), .CFG_ERR(cfg_err));
    smi_controller #(.STEP_GAP_CYC(20), .HOLD_MIN_CYC(10)) i_smi_controller (
        .REF_CLK(clk), .RST_B(rst_b), .LINK(link.ctl), .ORIENT_REQ(o_req),
        .READY_REQ(r_req), .INDEX_REQ(i_req), .INDEX_FWD(i_fwd),
        .INDEX_TARGET(i_tgt), .CLAMP_REQ(c_req), .CLAMP_TL(c_tl),
        .ORIENTED(oriented), .INDEXED(indexed), .BUSY(busy));
    smi_assertions i_smi_assertions (
        .REF_CLK(clk), .RST_B(rst_b),
        .orient_start_cmd(link.orient_start_cmd),
        .index_forward_cmd(link.index_forward_cmd),
        .index_reverse_cmd(link.index_reverse_cmd),
        .gear_select(link.gear_select), .machine_ready(link.machine_ready),
        .orient_done_out(link.orient_done_out),
        .index_done_out(link.index_done_out));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // spindle settles on the commanded angle, drifts off when coasting
    always @(posedge clk) begin
        #1;
        pos_raw = (drive_en === 1'b1) ? tgt_pos : 12'h0800;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic wait_sig(input int sel, input logic val);
        repeat (800) begin
            if ((sel == 0 ? oriented : sel == 1 ? indexed : busy) === val) break;
            step(1);
        end
    endtask : wait_sig
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report
    initial begin
        #200000;
        errors++;
        $display("BAD %0t watchdog expired", $time);
        final_report();
    end
    initial begin
        {rst_b, o_req, i_req, c_req, c_tl, ratio, i_tgt} = '0;
        {r_req, i_fwd, enc, zph} = 4'hF;
        sp_t = 16'h0003;
        mt_t = 16'h0005;
        inpos = 8'h0E;
        step(10);
        rst_b = 1'b1;
        step(2);
        chk(coast, 1'b1);
        chk(decel, 8'h14);
        chk(gain, 8'h64);
        chk(r_num, 16'h0003);
        chk(r_den, 16'h0005);
        $display("test reset finished");
        o_req = 1'b1;
        wait_sig(0, 1'b1);
        chk(oriented, 1'b1);
        chk(drive_en, 1'b1);
        chk(low_gear, 1'b1);
        for (int i = 0; i < 2; i++) begin
            i_fwd = (i == 0);
            i_tgt = tgt[i];
            i_req = 1'b1;
            wait_sig(2, 1'b1);
            i_req = 1'b0;
            i_tgt = ~tgt[i];
            step(25);
            wait_sig(1, 1'b1);
            chk(indexed, 1'b1);
            chk(tgt_pos, tgt[i]);
            chk(run_fwd, i == 0);
            wait_sig(2, 1'b0);
        end
        $display("test indexing finished");
        c_req = 1'b1;
        c_tl = 3'h5;
        step(5);
        chk(tl_out, 3'h5);
        c_req = 1'b0;
        o_req = 1'b0;
        step(5);
        chk(coast, 1'b1);
        chk(drive_en, 1'b0);
        i_req = 1'b1;
        step(100);
        chk(indexed, 1'b0);
        i_req = 1'b0;
        // out-of-range ratio code falls back to 1:1, so the stop still lands
        ratio = 3'h6;
        o_req = 1'b1;
        wait_sig(0, 1'b1);
        chk(oriented, 1'b1);
        r_req = 1'b0;
        step(5);
        chk(coast, 1'b1);
        chk(oriented, 1'b0);
        enc = 1'b0;
        step(3);
        chk(cfg_err, 1'b1);
        {sp_t, mt_t} = {16'h0001, 16'h0001};
        step(3);
        chk(cfg_err, 1'b0);
        zph = 1'b0;
        step(3);
        chk(cfg_err, 1'b1);
        $display("test abort and config finished");
        final_report();
    end
endmodule : tb_top
`default_nettype wire
